// ### hw/tdm_port_pkg.sv
package tdm_port_pkg;

	localparam int          WORD_BITS     = 16;
	localparam int          FIFO_DEPTH    = 16;
	localparam logic [4:0]  BIT_LAST      = 5'h0f;
	// master frame: sync low for one bit, then the word; gap bits follow
	localparam logic [4:0]  FRAME_BITS    = 5'h14;
	localparam logic [3:0]  BCLK_HALF     = 4'h4;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [15:0] SAMPLE_RESET  = 16'h0000;

	typedef enum logic [1:0] {
		PORT_IDLE  = 2'b00,
		PORT_SHIFT = 2'b01,
		PORT_GAP   = 2'b10
	} port_state_type;

	typedef struct packed {
		logic        is_ctrl;
		logic [15:0] data;
	} frame_word_type;

endpackage : tdm_port_pkg

// ### hw/tdm_serial_port.sv
// Overview of operation
// - role-select high makes the port frame master, low makes it slave.
// - master drives frame sync itself; slave takes it from outside.
// - falling frame sync starts a frame of shifting in and out.
// - outgoing bits change on the rising bit-clock edge.
// - incoming bits are sampled on the falling bit-clock edge.
// - data output is released outside frames and driven only inside.
// - outgoing stream carries converted samples and register read-back words.
// - delayed frame sync output feeds the next slave's frame sync.
// - delayed frame sync lasts exactly as long as the master's pulse.
// - power-down low stops the serial port and bit clock.
// - leaving power-down resumes with every register value kept.
// - power-down clears counters, port state, output enable and the clock and sync flops, never programmed registers.
// - hardware reset returns registers and port to defaults.
// - as master all timing comes from the master clock input; as slave bit clock and sync come from the pins.
`timescale 1ns/1ps

module tdm_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;
	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_r    <= '0;
			rd_r    <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tdm_fifo

////////////////////////////////////////////////////////////////////////////////
module tdm_serial_port (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        role_master,
	input  wire logic        power_down_n,
	input  wire logic        bclk_in,
	input  wire logic        frame_sync_in,
	output logic             frame_sync_out,
	output logic             frame_sync_oe,
	output logic             bclk_out,
	output logic             bclk_oe,
	input  wire logic        data_in,
	output logic             data_out,
	output logic             data_out_oe,
	output logic             delayed_frame_sync_out,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic [16:0] tx_word,
	output logic             rx_valid,
	output logic [15:0]      rx_word,
	output logic [15:0]      ctrl_word
);
	logic                          master_meta_r;
	logic                          master_r;
	logic                          pwr_meta_r;
	logic                          run_r;
	logic [3:0]                    div_r;
	logic                          bclk_r;
	logic                          bclk_prev_r;
	logic                          fs_prev_r;
	logic [4:0]                    mcnt_r;
	logic [4:0]                    bit_r;
	tdm_port_pkg::port_state_type  state_r;
	logic [15:0]                   shin_r;
	logic [15:0]                   shout_r;
	logic                          fs_out_r;
	logic                          dfs_r;
	logic                          dout_r;
	logic                          doe_r;
	logic                          rxv_r;
	logic [15:0]                   rxw_r;
	logic [15:0]                   ctrl_r;
	logic                          tx_tgt_ctrl_r;
	logic                          fifo_ready;
	logic                          q_valid;
	logic [16:0]                   q_data;
	logic                          q_pop;
	logic                          bclk_s;
	logic                          fs_s;
	logic                          rise;
	logic                          fall;
	logic                          fs_fall;
	tdm_port_pkg::frame_word_type  q_word;
	default clocking sys_cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	//////////////////////////////////////////////////////////////////////////
	// read-back and sample words wait here; producer stalls on tx_ready
	tdm_fifo #(
		.WIDTH (17),
		.DEPTH (tdm_port_pkg::FIFO_DEPTH)
	) u_tdm_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_valid  (tx_valid),
		.in_ready  (fifo_ready),
		.in_data   (tx_word),
		.out_valid (q_valid),
		.out_ready (q_pop),
		.out_data  (q_data)
	);
	assign q_word = tdm_port_pkg::frame_word_type'(q_data);

	//////////////////////////////////////////////////////////////////////////
	// input synchronisers; second stage alone feeds logic
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			master_meta_r <= 1'b0;
			master_r      <= 1'b0;
			pwr_meta_r    <= 1'b0;
			run_r         <= 1'b0;
		end else begin
			master_meta_r <= role_master;
			master_r      <= master_meta_r;
			pwr_meta_r    <= power_down_n;
			run_r         <= pwr_meta_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// bit clock: divided from sys_clk as master, else taken from the pin
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_r  <= 4'h0;
			bclk_r <= 1'b0;
		end else if (!run_r || !master_r) begin
			div_r  <= 4'h0;
			bclk_r <= 1'b0;
		end else if (div_r == tdm_port_pkg::BCLK_HALF) begin
			div_r  <= 4'h0;
			bclk_r <= !bclk_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	assign bclk_s  = master_r ? bclk_r : bclk_in;
	assign fs_s    = master_r ? fs_out_r : frame_sync_in;
	assign rise    = run_r && bclk_s && !bclk_prev_r;
	assign fall    = run_r && !bclk_s && bclk_prev_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bclk_prev_r <= 1'b0;
		end else begin
			bclk_prev_r <= bclk_s;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// master frame sync: low for one bit period per frame
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mcnt_r   <= 5'h00;
			fs_out_r <= 1'b1;
		end else if (!run_r || !master_r) begin
			mcnt_r   <= 5'h00;
			fs_out_r <= 1'b1;
		end else if (rise) begin
			fs_out_r <= (mcnt_r != 5'h00);
			mcnt_r   <= (mcnt_r == tdm_port_pkg::FRAME_BITS) ? 5'h00
				: mcnt_r + 5'h01;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// frame start and shifting; falling sync arms the frame on a rise
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fs_prev_r <= 1'b1;
		end else if (rise) begin
			fs_prev_r <= fs_s;
		end
	end

	// sync sampled on rising edges so master and slave see the same edge
	assign fs_fall = rise && fs_prev_r && !fs_s;
	assign q_pop   = fs_fall && q_valid && (state_r == tdm_port_pkg::PORT_IDLE);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r       <= tdm_port_pkg::PORT_IDLE;
			bit_r         <= 5'h00;
			shout_r       <= tdm_port_pkg::SAMPLE_RESET;
			dout_r        <= 1'b0;
			doe_r         <= 1'b0;
			tx_tgt_ctrl_r <= 1'b0;
		end else if (!run_r) begin
			state_r <= tdm_port_pkg::PORT_IDLE;
			bit_r   <= 5'h00;
			doe_r   <= 1'b0;
		end else begin
			unique case (state_r)
				tdm_port_pkg::PORT_IDLE: begin
					if (fs_fall) begin
						// empty queue sends a zero sample
						shout_r <= q_valid ? q_word.data
							: tdm_port_pkg::SAMPLE_RESET;
						tx_tgt_ctrl_r <= q_valid && q_word.is_ctrl;
						bit_r   <= 5'h00;
						doe_r   <= 1'b1;
						dout_r  <= q_valid ? q_word.data[15] : 1'b0;
						state_r <= tdm_port_pkg::PORT_SHIFT;
					end
				end
				tdm_port_pkg::PORT_SHIFT: begin
					if (rise) begin
						if (bit_r == tdm_port_pkg::BIT_LAST) begin
							doe_r   <= 1'b0;
							state_r <= tdm_port_pkg::PORT_GAP;
						end else begin
							shout_r <= {shout_r[14:0], 1'b0};
							dout_r  <= shout_r[14];
							bit_r   <= bit_r + 5'h01;
						end
					end
				end
				tdm_port_pkg::PORT_GAP: begin
					// wait for sync to go high before the next frame
					if (rise && fs_s) begin
						state_r <= tdm_port_pkg::PORT_IDLE;
					end
				end
				default: begin
					state_r <= tdm_port_pkg::PORT_IDLE;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// receive: sample on falling edges while shifting
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shin_r <= 16'h0000;
			rxv_r  <= 1'b0;
			rxw_r  <= 16'h0000;
			ctrl_r <= tdm_port_pkg::CTRL_RESET;
		end else begin
			rxv_r <= 1'b0;
			if (run_r && fall && state_r == tdm_port_pkg::PORT_SHIFT) begin
				shin_r <= {shin_r[14:0], data_in};
				if (bit_r == tdm_port_pkg::BIT_LAST) begin
					// control frames update the register; samples go out
					if (tx_tgt_ctrl_r) begin
						ctrl_r <= {shin_r[14:0], data_in};
					end else begin
						rxw_r <= {shin_r[14:0], data_in};
						rxv_r <= 1'b1;
					end
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// delayed sync: one bit after the sampled sync, two after the master's sync output; same width as the master pulse
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dfs_r <= 1'b1;
		end else if (!run_r) begin
			dfs_r <= 1'b1;
		end else if (rise) begin
			dfs_r <= fs_prev_r;
		end
	end
	//////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			frame_sync_out         <= 1'b1;
			frame_sync_oe          <= 1'b0;
			bclk_out               <= 1'b0;
			bclk_oe                <= 1'b0;
			data_out               <= 1'b0;
			data_out_oe            <= 1'b0;
			delayed_frame_sync_out <= 1'b1;
			tx_ready               <= 1'b0;
			rx_valid               <= 1'b0;
			rx_word                <= 16'h0000;
			ctrl_word              <= tdm_port_pkg::CTRL_RESET;
		end else begin
			frame_sync_out         <= fs_out_r;
			frame_sync_oe          <= master_r && run_r;
			bclk_out               <= bclk_r;
			bclk_oe                <= master_r && run_r;
			data_out               <= dout_r;
			data_out_oe            <= doe_r;
			delayed_frame_sync_out <= dfs_r;
			tx_ready               <= fifo_ready;
			rx_valid               <= rxv_r;
			rx_word                <= rxw_r;
			ctrl_word              <= ctrl_r;
		end
	end
	//////////////////////////////////////////////////////////////////////////

	// enable rises with the move into shifting, so same-cycle implication
	dout_released_a: assert property (
		(state_r != tdm_port_pkg::PORT_SHIFT) |-> !doe_r)
		else $error("data output driven outside a frame");
	frame_start_a: assert property (
		(fs_fall && state_r == tdm_port_pkg::PORT_IDLE) |=>
		(state_r == tdm_port_pkg::PORT_SHIFT && doe_r))
		else $error("frame did not start on falling sync");
	dfs_follow_a: assert property (
		(run_r && rise) |=> (dfs_r == $past(fs_prev_r)))
		else $error("delayed sync does not mirror sync");
	pdown_idle_a: assert property (
		!run_r |=> (state_r == tdm_port_pkg::PORT_IDLE && bit_r == 5'h00))
		else $error("port active in power-down");
	ctrl_kept_a: assert property (
		!run_r |=> $stable(ctrl_r))
		else $error("register changed in power-down");
	slave_no_drive_a: assert property (
		!master_r |=> (!frame_sync_oe && !bclk_oe))
		else $error("slave drives sync or bit clock");
	tx_change_rise_a: assert property (
		(state_r == tdm_port_pkg::PORT_SHIFT && !rise) |=> $stable(dout_r))
		else $error("output bit changed off a rising edge");
	rx_on_fall_a: assert property (
		!fall |=> $stable(shin_r))
		else $error("input sampled off a falling edge");
	frame_cov_c: cover property (fs_fall ##[1:400] rxv_r);
	ctrl_cov_c: cover property (tx_tgt_ctrl_r && state_r == tdm_port_pkg::PORT_GAP);
	pdown_cov_c: cover property (state_r == tdm_port_pkg::PORT_SHIFT ##1 !run_r);
endmodule : tdm_serial_port

// ### testbench/dsp_port_model.sv
`timescale 1ns/1ps

module dsp_port_model (
	output logic        bclk,
	output logic        fsync,
	output logic        din,
	input  wire logic   dout,
	input  wire logic   dout_oe,
	output logic [15:0] got,
	output logic        oe_ok
);

	initial begin
		bclk  = 1'b0;
		fsync = 1'b1;
		din   = 1'b0;
		got   = 16'h0000;
		oe_ok = 1'b0;
	end

	// slave frame: sync low for the first bit, 16 bits, then 4 gap bits
	// bit clock stands still outside frames
	task automatic frame(input logic [15:0] w);
		oe_ok = 1'b1;
		fsync = 1'b0;
		for (int i = 19; i >= 0; i--) begin
			if (i >= 4)
				din = w[i-4];
			else
				din = ~din;
			#20 bclk = 1'b1;
			#40 bclk = 1'b0;
			if (i >= 4) begin
				got[i-4] = dout;
				oe_ok    = oe_ok & dout_oe;
			end
			fsync = 1'b1;
			#20;
		end
		// released line: toggled so a stale level cannot pass
		din = ~din;
	endtask : frame

endmodule : dsp_port_model

// ### testbench/tb_tdm_serial_port.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
 $display("FAIL %s exp %h got %h", nm, ex, gt); n_errors++; end end

module tb_tdm_serial_port;

	logic        sys_clk, resetn, role_master, power_down_n;
	logic        tx_valid, tx_ready, rx_valid, rx_seen;
	logic [16:0] tx_word;
	logic [15:0] rx_word, ctrl_word, rx_last, m_got;
	logic        fs_out, fs_oe, bclk_out, bclk_oe, dout, dout_oe, dfs;
	logic        m_bclk, m_fs, m_din, m_ok;
	int          n_errors, cmp_count;
	wire         bclk_pin = bclk_oe ? bclk_out : m_bclk;
	wire         fs_pin   = fs_oe ? fs_out : m_fs;

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	tdm_serial_port u_tdm_serial_port (
		.sys_clk(sys_clk), .resetn(resetn), .role_master(role_master),
		.power_down_n(power_down_n), .bclk_in(bclk_pin),
		.frame_sync_in(fs_pin), .frame_sync_out(fs_out),
		.frame_sync_oe(fs_oe), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
		.data_in(m_din), .data_out(dout), .data_out_oe(dout_oe),
		.delayed_frame_sync_out(dfs), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_word(tx_word), .rx_valid(rx_valid),
		.rx_word(rx_word), .ctrl_word(ctrl_word)
	);

	dsp_port_model u_dsp_port_model (
		.bclk(m_bclk), .fsync(m_fs), .din(m_din), .dout(dout),
		.dout_oe(dout_oe), .got(m_got), .oe_ok(m_ok)
	);

	// rx_valid stands one cycle only
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			rx_seen <= 1'b1;
			rx_last <= rx_word;
		end
	end

	////////////////////////////////////////////////////////////////////////

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic hang(input string nm);
		$display("FAIL %s exp done got timeout", nm);
		n_errors++;
		tally_and_finish();
	endtask : hang

	task automatic push(input logic [16:0] w);
		int k;
		k = 0;
		while (tx_ready !== 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		if (k == 100)
			hang("tx_ready");
		tx_valid = 1'b1;
		tx_word  = w;
		tick(1);
		tx_valid = 1'b0;
		tick(1);
	endtask : push

	task automatic slave_frame(input logic [16:0] tx,
			input logic [15:0] rxw);
		push(tx);
		rx_seen = 1'b0;
		u_dsp_port_model.frame(rxw);
		tick(4);
		`CHECK("dout word", tx[15:0], m_got)
		`CHECK("oe in frame", 1'b1, m_ok)
		`CHECK("oe idle", 1'b0, dout_oe)
		if (tx[16]) begin
			`CHECK("ctrl word", rxw, ctrl_word)
		end else begin
			`CHECK("rx valid", 1'b1, rx_seen)
			`CHECK("rx word", rxw, rx_last)
		end
	endtask : slave_frame

	////////////////////////////////////////////////////////////////////////

	task automatic t_reset_vals;
		`CHECK("ctrl rst", tdm_port_pkg::CTRL_RESET, ctrl_word)
		`CHECK("fs rst", 1'b1, fs_out)
		`CHECK("dfs rst", 1'b1, dfs)
		`CHECK("fs oe rst", 1'b0, fs_oe)
		`CHECK("bclk oe rst", 1'b0, bclk_oe)
		`CHECK("dout oe rst", 1'b0, dout_oe)
	endtask : t_reset_vals

	task automatic t_frames;
		slave_frame({1'b0, 16'ha5c3}, 16'h3c5a);
		slave_frame({1'b0, 16'h8001}, 16'h7ffe);
		slave_frame({1'b1, 16'h1234}, 16'hbeef);
		slave_frame({1'b0, 16'hffff}, 16'h0000);
		`CHECK("ctrl kept", 16'hbeef, ctrl_word)
	endtask : t_frames

	task automatic t_fifo;
		int n;
		n = 0;
		for (int k = 0; k < 40; k++) begin
			if (tx_ready === 1'b1) begin
				tx_valid = 1'b1;
				tx_word  = {1'b0, 16'h1000 + 16'(n)};
				tick(1);
				tx_valid = 1'b0;
				n++;
			end
			tick(1);
		end
		`CHECK("fifo fill", tdm_port_pkg::FIFO_DEPTH, n)
		for (int i = 0; i < 17; i++) begin
			u_dsp_port_model.frame(16'h0f0f);
			tick(4);
			// empty fifo yields a zero sample
			`CHECK("drain", (i < 16) ? 16'h1000 + 16'(i) : 16'h0, m_got)
		end
	endtask : t_fifo

	task automatic t_power_down;
		power_down_n = 1'b0;
		tick(4);
		rx_seen = 1'b0;
		u_dsp_port_model.frame(16'h1111);
		tick(4);
		`CHECK("pd oe", 1'b0, m_ok)
		`CHECK("pd rx", 1'b0, rx_seen)
		`CHECK("pd ctrl", 16'hbeef, ctrl_word)
		power_down_n = 1'b1;
		tick(4);
		`CHECK("wake ctrl", 16'hbeef, ctrl_word)
		slave_frame({1'b0, 16'h0ff0}, 16'h1357);
	endtask : t_power_down

	task automatic t_master;
		int k, n1, n2, n3;
		role_master = 1'b1; // lone master: board straps delayed sync high
		k = 0;
		while (!(fs_oe === 1'b1 && fs_out === 1'b0) && k < 400) begin
			tick(1);
			k++;
		end
		if (k == 400)
			hang("master sync");
		`CHECK("bclk oe", 1'b1, bclk_oe)
		`CHECK("dfs late", 1'b1, dfs)
		n1 = 0;
		n2 = 0;
		n3 = 0;
		for (k = 0; k < 60; k++) begin
			n1 += (fs_out === 1'b0);
			n2 += (dfs === 1'b0);
			n3 += (bclk_out === 1'b1);
			tick(1);
		end
		`CHECK("sync width", 10, n1)
		`CHECK("dfs width", n1, n2)
		// six whole bit periods of five high cycles each
		`CHECK("bclk high", 30, n3)
		role_master = 1'b0;
		k = 0;
		while ((fs_oe !== 1'b0 || bclk_oe !== 1'b0) && k < 400) begin
			tick(1);
			k++;
		end
		`CHECK("slave again", 1'b1, k < 400)
		if (k == 400)
			tally_and_finish();
	endtask : t_master

	////////////////////////////////////////////////////////////////////////

	initial begin
		n_errors     = 0;
		cmp_count    = 0;
		resetn       = 1'b0;
		role_master  = 1'b0; // lone slave: board straps delayed sync low
		power_down_n = 1'b1;
		tx_valid     = 1'b0;
		tx_word      = 17'h00000;
		rx_seen      = 1'b0;
		tick(4);
		resetn = 1'b1;
		tick(3);
		t_reset_vals();
		t_frames();
		t_fifo();
		t_power_down();
		t_master();
		// reset in mid-run must drop the programmed control word
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		tick(3);
		t_reset_vals();
		tally_and_finish();
	end

endmodule : tb_tdm_serial_port
